// *** logic/cfr_defines.svh ***
// Register offsets, field positions, reset values and decode constants
`ifndef CFR_DEFINES_SVH
`define CFR_DEFINES_SVH

`define CFR_ADDR_GEN      5'h01
`define CFR_ADDR_CH1      5'h02
`define CFR_ADDR_CH2      5'h03
`define CFR_ADDR_BOOT     5'h04
`define CFR_ADDR_ENABLE   5'h05
`define CFR_ADDR_LEVEL    5'h06
`define CFR_ADDR_DRIVER   5'h07
`define CFR_ADDR_RESPONSE 5'h08
`define CFR_ADDR_MODE     5'h0a

`define CFR_GEN_W1C_MASK  16'h01fb
`define CFR_GEN_FAILSAFE  2
`define CFR_GEN_SERIAL    0
`define CFR_CH_W1C_MASK   16'h01ff
`define CFR_CH_SWITCH     5
`define CFR_CH_LOWGATE    7
`define CFR_CH_HIGHGATE   6
`define CFR_CH_OVERCUR    4

`define CFR_BOOT_LOCK     15
`define CFR_BOOT_MATCH    14

`define CFR_ENABLE_MASK   16'h0003
`define CFR_DRIVER_RESET  16'hf5aa
`define CFR_RESP_MASK     16'h00ff
`define CFR_RESP_GATE     7
`define CFR_RESP_SW2      6
`define CFR_RESP_SW1      5
`define CFR_RESP_OC2      4
`define CFR_RESP_OC1      3

`define CFR_NS_10         7'h0a
`define CFR_NS_20         7'h14
`define CFR_NS_40         7'h28
`define CFR_NS_60         7'h3c
`define CFR_MOHM_555      10'h22b
`define CFR_MOHM_280      10'h118
`define CFR_MOHM_185      10'h0b9
`define CFR_MOHM_140      10'h08c

`endif

// *** logic/cfr_pkg.sv ***
// Types shared by the converter fault and configuration register bank
package cfr_pkg;
  typedef logic [15:0] cfr_word_t;
  typedef logic [4:0]  cfr_addr_t;
  typedef logic [2:0]  cfr_mode_t;
  // Buck output level index: 3.3, 4.5, 5, 5.5, 6 V
  typedef enum logic [2:0] {
    CFR_BUCK_3V3 = 3'h0,
    CFR_BUCK_4V5 = 3'h1,
    CFR_BUCK_5V0 = 3'h2,
    CFR_BUCK_5V5 = 3'h3,
    CFR_BUCK_6V0 = 3'h4
  } cfr_buck_t;
endpackage : cfr_pkg

// *** logic/cfr_regs.sv ***
// Fault, startup and configuration register bank behind the serial frame decoder
`timescale 1ns/1ps
`default_nettype none
`include "cfr_defines.svh"

module cfr_regs (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // Decoded serial frames
  input  wire logic                 frame_start,
  input  wire logic                 frame_done,
  input  wire logic                 frame_write,
  input  wire cfr_pkg::cfr_addr_t   frame_addr,
  input  wire cfr_pkg::cfr_word_t   frame_data,
  input  wire logic                 frame_error,
  output var  cfr_pkg::cfr_word_t   resp_data,
  // Fault events
  input  wire logic [6:0]           gen_fault_evt,
  input  wire logic                 failsafe_open_flag,
  input  wire logic [1:0][7:0]      ch_fault_evt,
  input  wire logic [1:0]           sw_short_gnd,
  input  wire logic [1:0]           sw_short_high,
  // Startup results
  input  wire logic                 boot_report_valid,
  input  wire logic [3:0]           boot_comp_fault,
  input  wire logic [1:0]           sense_fault_at_boot,
  input  wire logic [1:0]           boot_sync_state,
  input  wire logic                 boot_follower,
  input  wire logic                 boot_leader,
  input  wire logic                 pinstrap_only_operation,
  input  wire cfr_pkg::cfr_mode_t   pin_strap_mode,
  // Converter control
  output var  logic [1:0]           ch_enable,
  output var  logic [1:0]           ch_hiccup,
  output var  logic [1:0][7:0]      ch_target_level,
  output var  cfr_pkg::cfr_buck_t   ch1_buck_level,
  output var  cfr_pkg::cfr_buck_t   ch2_buck_level,
  output var  logic [1:0]           ch_buck_mode,
  output var  logic [1:0][6:0]      ch_nonoverlap_ns,
  output var  logic [3:0][9:0]      gate_strength_mohm,
  output var  cfr_pkg::cfr_mode_t   operating_topology
);
  import cfr_pkg::*;

  function automatic cfr_buck_t buck_decode(input logic [7:0] code);
    if (code > 8'h03) begin
      buck_decode = CFR_BUCK_6V0;
    end else begin
      buck_decode = cfr_buck_t'({1'b0, code[1:0]});
    end
  endfunction : buck_decode

  function automatic logic [6:0] nonoverlap_decode(input logic [1:0] sel);
    case (sel)
      2'h0:    nonoverlap_decode = `CFR_NS_10;
      2'h1:    nonoverlap_decode = `CFR_NS_20;
      2'h2:    nonoverlap_decode = `CFR_NS_40;
      default: nonoverlap_decode = `CFR_NS_60;
    endcase
  endfunction : nonoverlap_decode

  function automatic logic [9:0] strength_decode(input logic [1:0] sel);
    case (sel)
      2'h0:    strength_decode = `CFR_MOHM_555;
      2'h1:    strength_decode = `CFR_MOHM_280;
      2'h2:    strength_decode = `CFR_MOHM_185;
      default: strength_decode = `CFR_MOHM_140;
    endcase
  endfunction : strength_decode

  cfr_word_t             gen_q, gen_d;
  cfr_word_t [1:0]       ch_q, ch_d;
  cfr_word_t             boot_q, boot_d;
  logic      [1:0]       en_q, en_d;
  cfr_word_t             level_q, level_d;
  cfr_word_t             drv_q, drv_d;
  cfr_word_t             resp_cfg_q, resp_cfg_d;
  cfr_mode_t             topo_q, topo_d;
  logic                  lock_q, lock_d;
  cfr_addr_t             last_addr_q, last_addr_d;
  cfr_word_t             resp_q, resp_d;
  logic      [1:0]       hiccup_q, hiccup_d;
  logic      [1:0]       buck_q, buck_d;
  cfr_buck_t [1:0]       buck_lvl_q, buck_lvl_d;
  logic      [1:0][6:0]  ovl_q, ovl_d;
  logic      [3:0][9:0]  str_q, str_d;

  logic                  wr;
  cfr_word_t             gen_set;
  cfr_word_t [1:0]       ch_set;
  logic      [1:0]       short_hit;
  logic      [1:0]       cut_en;
  cfr_word_t             rd_now;

  function automatic cfr_word_t read_mux(input cfr_addr_t a, input cfr_word_t g,
                                         input cfr_word_t c1, input cfr_word_t c2,
                                         input cfr_word_t b, input logic [1:0] e,
                                         input cfr_word_t l, input cfr_word_t d,
                                         input cfr_word_t r);
    // Reserved positions are not stored, so they read as zero; the driver register keeps all 16 bits, unused bits 15:12 included
    if (a == `CFR_ADDR_GEN) begin
      read_mux = g;
    end else if (a == `CFR_ADDR_CH1) begin
      read_mux = c1;
    end else if (a == `CFR_ADDR_CH2) begin
      read_mux = c2;
    end else if (a == `CFR_ADDR_BOOT) begin
      read_mux = b;
    end else if (a == `CFR_ADDR_ENABLE) begin
      read_mux = {14'h0000, e};
    end else if (a == `CFR_ADDR_LEVEL) begin
      read_mux = l;
    end else if (a == `CFR_ADDR_DRIVER) begin
      read_mux = d;
    end else if (a == `CFR_ADDR_RESPONSE) begin
      read_mux = r;
    end else begin
      read_mux = 16'h0000;
    end
  endfunction : read_mux

  always_comb begin
    wr = frame_done & frame_write;
    gen_set = {7'h00, gen_fault_evt[6:1], 1'b0, gen_fault_evt[0], 1'b0};
    // Bad edge count or check failure
    gen_set[`CFR_GEN_SERIAL] = frame_error;
    // Set beats the clear in the same cycle
    gen_d = gen_q;
    if (wr && frame_addr == `CFR_ADDR_GEN) begin
      gen_d = gen_q & ~(frame_data & `CFR_GEN_W1C_MASK);
    end
    gen_d = gen_d | gen_set;
    gen_d[`CFR_GEN_FAILSAFE] = failsafe_open_flag;

    for (int i = 0; i < 2; i++) begin
      // Either short direction sets the flag
      short_hit[i] = sw_short_gnd[i] | sw_short_high[i];
      ch_set[i] = {7'h00, ch_fault_evt[i][7:5], short_hit[i], ch_fault_evt[i][4:0]};
      ch_d[i] = ch_q[i];
      // Second register decoded at its own offset
      if (wr && frame_addr == (i == 0 ? `CFR_ADDR_CH1 : `CFR_ADDR_CH2)) begin
        ch_d[i] = ch_q[i] & ~(frame_data & `CFR_CH_W1C_MASK);
      end
      ch_d[i] = ch_d[i] | ch_set[i];
    end

    lock_d = lock_q | (wr && frame_addr == `CFR_ADDR_MODE);
    topo_d = (wr && frame_addr == `CFR_ADDR_MODE) ? frame_data[2:0] : topo_q;

    boot_d = boot_q;
    if (boot_report_valid) begin
      boot_d[10:0] = {boot_comp_fault, sense_fault_at_boot, boot_sync_state,
                      boot_follower, boot_leader, pinstrap_only_operation};
    end
    boot_d[`CFR_BOOT_LOCK] = lock_q;
    boot_d[`CFR_BOOT_MATCH] = (topo_q == pin_strap_mode);

    // Gate, switch short or overcurrent response selection
    cut_en[0] = (short_hit[0] & resp_cfg_q[`CFR_RESP_SW1])
              | ((ch_fault_evt[0][6] | ch_fault_evt[0][5]) & resp_cfg_q[`CFR_RESP_GATE])
              | (ch_fault_evt[0][4] & resp_cfg_q[`CFR_RESP_OC1]);
    cut_en[1] = (short_hit[1] & resp_cfg_q[`CFR_RESP_SW2])
              | ((ch_fault_evt[1][6] | ch_fault_evt[1][5]) & resp_cfg_q[`CFR_RESP_GATE])
              | (ch_fault_evt[1][4] & resp_cfg_q[`CFR_RESP_OC2]);
    hiccup_d[0] = (short_hit[0] & ~resp_cfg_q[`CFR_RESP_SW1])
                | ((ch_fault_evt[0][6] | ch_fault_evt[0][5]) & ~resp_cfg_q[`CFR_RESP_GATE])
                | (ch_fault_evt[0][4] & ~resp_cfg_q[`CFR_RESP_OC1]);
    hiccup_d[1] = (short_hit[1] & ~resp_cfg_q[`CFR_RESP_SW2])
                | ((ch_fault_evt[1][6] | ch_fault_evt[1][5]) & ~resp_cfg_q[`CFR_RESP_GATE])
                | (ch_fault_evt[1][4] & ~resp_cfg_q[`CFR_RESP_OC2]);

    // Host request, cut by a fault that asks for it
    en_d = en_q;
    if (wr && frame_addr == `CFR_ADDR_ENABLE) begin
      en_d = frame_data[1:0];
    end
    en_d = en_d & ~cut_en;

    level_d = (wr && frame_addr == `CFR_ADDR_LEVEL) ? frame_data : level_q;
    drv_d = (wr && frame_addr == `CFR_ADDR_DRIVER) ? frame_data : drv_q;
    resp_cfg_d = (wr && frame_addr == `CFR_ADDR_RESPONSE) ?
                 (frame_data & `CFR_RESP_MASK) : resp_cfg_q;

    // Previous frame's register sampled as the next frame opens
    last_addr_d = frame_done ? frame_addr : last_addr_q;
    resp_d = frame_start ? rd_now : resp_q;

    buck_d[0] = (topo_q == 3'h1) | (topo_q == 3'h5) | (topo_q == 3'h6) | (topo_q == 3'h7);
    buck_d[1] = (topo_q == 3'h6) | (topo_q == 3'h7);
    buck_lvl_d[0] = buck_decode(level_q[7:0]);
    buck_lvl_d[1] = buck_decode(level_q[15:8]);
    ovl_d[0] = nonoverlap_decode(drv_q[9:8]);
    ovl_d[1] = nonoverlap_decode(drv_q[11:10]);
  end

  assign rd_now = read_mux(last_addr_q, gen_q, ch_q[0], ch_q[1], boot_q, en_q,
                           level_q, drv_q, resp_cfg_q);

  // Order: high side ch1, high side ch2, low side ch1, low side ch2
  for (genvar k = 0; k < 4; k++) begin : g_strength
    assign str_d[k] = strength_decode(drv_q[2*k+1:2*k]);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gen_q       <= 16'h0000;
      ch_q        <= '{16'h0000, 16'h0000};
      boot_q      <= 16'h0000;
      en_q        <= 2'h0;
      level_q     <= 16'h0000;
      drv_q       <= `CFR_DRIVER_RESET;
      resp_cfg_q  <= 16'h0000;
      topo_q      <= 3'h0;
      lock_q      <= 1'b0;
      last_addr_q <= 5'h00;
      resp_q      <= 16'h0000;
      hiccup_q    <= 2'h0;
      buck_q      <= 2'h0;
      buck_lvl_q  <= '{CFR_BUCK_3V3, CFR_BUCK_3V3};
      ovl_q       <= '{`CFR_NS_20, `CFR_NS_20};
      str_q       <= '{`CFR_MOHM_185, `CFR_MOHM_185, `CFR_MOHM_185, `CFR_MOHM_185};
    end else begin
      gen_q       <= gen_d;
      ch_q        <= ch_d;
      boot_q      <= boot_d;
      en_q        <= en_d;
      level_q     <= level_d;
      drv_q       <= drv_d;
      resp_cfg_q  <= resp_cfg_d;
      topo_q      <= topo_d;
      lock_q      <= lock_d;
      last_addr_q <= last_addr_d;
      resp_q      <= resp_d;
      hiccup_q    <= hiccup_d;
      buck_q      <= buck_d;
      buck_lvl_q  <= buck_lvl_d;
      ovl_q       <= ovl_d;
      str_q       <= str_d;
    end
  end

  // Target levels drive straight from the register; buck levels come from the registered decode
  assign resp_data          = resp_q;
  assign ch_enable          = en_q;
  assign ch_hiccup          = hiccup_q;
  assign ch_target_level[0] = level_q[7:0];
  assign ch_target_level[1] = level_q[15:8];
  assign ch1_buck_level     = buck_lvl_q[0];
  assign ch2_buck_level     = buck_lvl_q[1];
  assign ch_buck_mode       = buck_q;
  assign ch_nonoverlap_ns   = ovl_q;
  assign gate_strength_mohm = str_q;
  assign operating_topology = topo_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_gen_clear;
    wr && frame_addr == `CFR_ADDR_GEN && frame_data[8] && !gen_fault_evt[6]
      |=> !gen_q[8];
  endproperty
  a_gen_clear: assert property (p_gen_clear) else $error("thermal flag not cleared");

  property p_set_wins;
    ch_fault_evt[0][0] |=> ch_q[0][0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("channel flag event lost");

  property p_serial;
    frame_error ##1 !(wr && frame_addr == `CFR_ADDR_GEN) |-> gen_q[`CFR_GEN_SERIAL];
  endproperty
  a_serial: assert property (p_serial) else $error("serial error flag missing");

  property p_lock;
    wr && frame_addr == `CFR_ADDR_MODE |=> ##1 boot_q[`CFR_BOOT_LOCK];
  endproperty
  a_lock: assert property (p_lock) else $error("lock bit not set");

  property p_match;
    ##2 boot_q[`CFR_BOOT_MATCH] == ($past(topo_q, 1) == $past(pin_strap_mode, 1));
  endproperty
  a_match: assert property (p_match) else $error("match bit wrong");

  property p_reserved;
    ch_q[1][15:9] == 7'h00 && resp_cfg_q[15:8] == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_sw_cut;
    resp_cfg_q[`CFR_RESP_SW1] && sw_short_high[0] |=> !en_q[0] && !hiccup_q[0] ##1 !ch_enable[0];
  endproperty
  a_sw_cut: assert property (p_sw_cut) else $error("switch short kept enable");

  property p_sw_hiccup;
    !resp_cfg_q[`CFR_RESP_SW2] && sw_short_gnd[1] |=> hiccup_q[1];
  endproperty
  a_sw_hiccup: assert property (p_sw_hiccup) else $error("no hiccup on short");

  property p_buck;
    level_q[7:0] > 8'h03 |=> ch1_buck_level == CFR_BUCK_6V0;
  endproperty
  a_buck: assert property (p_buck) else $error("buck decode wrong");

  property p_ovl;
    drv_q[9:8] == 2'h3 |=> ch_nonoverlap_ns[0] == `CFR_NS_60;
  endproperty
  a_ovl: assert property (p_ovl) else $error("non-overlap decode wrong");

  property p_resp;
    frame_start |=> resp_data == $past(rd_now);
  endproperty
  a_resp: assert property (p_resp) else $error("response not latched");

  c_enable: cover property (wr && frame_addr == `CFR_ADDR_ENABLE ##1 en_q == 2'h3);
  c_cut:    cover property (en_q[1] ##1 !en_q[1] && !$past(wr));
  c_lock:   cover property ($rose(boot_q[`CFR_BOOT_LOCK]));
  c_race:   cover property (wr && frame_addr == `CFR_ADDR_CH1 && ch_fault_evt[0][0]);
endmodule : cfr_regs

`default_nettype wire

// *** testbench/cfr_host.sv ***
// Host side model that issues decoded serial frames to the register bank
`timescale 1ns/1ps
`default_nettype none
module cfr_host (
  // Clock
  input  wire logic               clock,
  // Decoded frame signals
  output var  logic               frame_start,
  output var  logic               frame_done,
  output var  logic               frame_write,
  output var  cfr_pkg::cfr_addr_t frame_addr,
  output var  cfr_pkg::cfr_word_t frame_data,
  output var  logic               frame_error,
  input  wire cfr_pkg::cfr_word_t resp_data
);
  import cfr_pkg::*;
  initial begin
    frame_start = 1'h0;
    frame_done  = 1'h0;
    frame_write = 1'h0;
    frame_addr  = 5'h00;
    frame_data  = 16'h0000;
    frame_error = 1'h0;
  end
  task automatic frame(input logic wr, input cfr_addr_t a, input cfr_word_t d,
                       output cfr_word_t q);
    @(posedge clock);
    frame_start <= 1'h1;
    @(posedge clock);
    frame_start <= 1'h0;
    frame_done  <= 1'h1;
    frame_write <= wr;
    frame_addr  <= a;
    frame_data  <= d;
    // Answer of the previous frame lands with the start
    #1 q = resp_data;
    @(posedge clock);
    // Released fields must not keep showing the last value
    frame_done  <= 1'h0;
    frame_write <= ~wr;
    frame_addr  <= ~a;
    frame_data  <= ~d;
  endtask : frame
  task automatic bad_frame();
    @(posedge clock);
    frame_start <= 1'h1;
    @(posedge clock);
    frame_start <= 1'h0;
    frame_error <= 1'h1;
    @(posedge clock);
    frame_error <= 1'h0;
  endtask : bad_frame
endmodule : cfr_host
`default_nettype wire

// *** testbench/converter_fault_config_regs_tb_top.sv ***
// Self-checking bench for the fault and configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "cfr_defines.svh"
module converter_fault_config_regs_tb_top;
  import cfr_pkg::*;
  logic            clock = 1'h0;
  logic            rst_n = 1'h0;
  logic            frame_start, frame_done, frame_write, frame_error;
  cfr_addr_t       frame_addr;
  cfr_word_t       frame_data, resp_data, q;
  logic [6:0]      gen_fault_evt = 7'h00;
  logic            failsafe_open_flag = 1'h0;
  logic [1:0][7:0] ch_fault_evt = 16'h0000;
  logic [1:0]      sw_short_gnd = 2'h0, sw_short_high = 2'h0;
  logic            boot_report_valid = 1'h0;
  logic [3:0]      boot_comp_fault = 4'h0;
  logic [1:0]      sense_fault_at_boot = 2'h0, boot_sync_state = 2'h0;
  logic            boot_follower = 1'h0, boot_leader = 1'h0, pinstrap_only_operation = 1'h0;
  // Strap differs from reset topology so match starts clear
  cfr_mode_t       pin_strap_mode = 3'h6;
  logic [1:0]      ch_enable, ch_hiccup, ch_buck_mode;
  logic [1:0][7:0] ch_target_level;
  cfr_buck_t       ch1_buck_level, ch2_buck_level;
  logic [1:0][6:0] ch_nonoverlap_ns;
  logic [3:0][9:0] gate_strength_mohm;
  cfr_mode_t       operating_topology;
  int              err_total = 0, checks_done = 0, cycles = 0;

  cfr_regs dut (.clock, .rst_n, .frame_start, .frame_done, .frame_write, .frame_addr,
    .frame_data, .frame_error, .resp_data, .gen_fault_evt, .failsafe_open_flag,
    .ch_fault_evt, .sw_short_gnd, .sw_short_high, .boot_report_valid, .boot_comp_fault,
    .sense_fault_at_boot, .boot_sync_state, .boot_follower, .boot_leader,
    .pinstrap_only_operation, .pin_strap_mode, .ch_enable, .ch_hiccup, .ch_target_level,
    .ch1_buck_level, .ch2_buck_level, .ch_buck_mode, .ch_nonoverlap_ns,
    .gate_strength_mohm, .operating_topology);
  cfr_host host (.clock, .frame_start, .frame_done, .frame_write, .frame_addr,
    .frame_data, .frame_error, .resp_data);

  always #10 clock = ~clock;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic check(input string n, input logic [39:0] s, input logic [39:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic wr(input cfr_addr_t a, input cfr_word_t d);
    host.frame(1'h1, a, d, q);
    // Decoded outputs trail the register by one more edge
    @(posedge clock);
    #1;
  endtask : wr
  // Read answer arrives in the following frame
  task automatic rd(input string n, input cfr_addr_t a, input cfr_word_t e);
    host.frame(1'h0, a, 16'h0000, q);
    host.frame(1'h0, a, 16'h0000, q);
    check(n, q, e);
  endtask : rd

  task automatic t_reset();
    for (int i = 1; i < 9; i++) rd("reset", 5'(i), (i == 7) ? 16'hf5aa : 16'h0000);
    check("nonoverlap reset", ch_nonoverlap_ns, {7'h14, 7'h14});
    check("strength reset", gate_strength_mohm, {4{10'h0b9}});
    check("enable reset", ch_enable, 2'h0);
  endtask : t_reset

  task automatic t_general();
    logic [15:0] e;
    for (int k = 0; k < 7; k++) begin
      e = 16'h0001 << ((k == 0) ? 1 : k + 2);
      @(posedge clock) gen_fault_evt <= 7'h01 << k;
      @(posedge clock) gen_fault_evt <= 7'h00;
      rd("general set", `CFR_ADDR_GEN, e);
      wr(`CFR_ADDR_GEN, ~e);
      rd("general zero write", `CFR_ADDR_GEN, e);
      wr(`CFR_ADDR_GEN, e);
      rd("general clear", `CFR_ADDR_GEN, 16'h0000);
    end
    @(posedge clock) gen_fault_evt <= 7'h40;
    failsafe_open_flag <= 1'h1;
    wr(`CFR_ADDR_GEN, 16'hffff);
    rd("live fault", `CFR_ADDR_GEN, 16'h0104);
    @(posedge clock) gen_fault_evt <= 7'h00;
    failsafe_open_flag <= 1'h0;
    wr(`CFR_ADDR_GEN, 16'hffff);
    host.bad_frame();
    rd("serial error", `CFR_ADDR_GEN, 16'h0001);
    wr(`CFR_ADDR_GEN, 16'h0001);
    rd("serial clear", `CFR_ADDR_GEN, 16'h0000);
  endtask : t_general

  task automatic t_channel();
    logic [15:0] e;
    for (int c = 0; c < 2; c++) for (int k = 0; k < 10; k++) begin
      e = 16'h0001 << ((k < 5) ? k : (k < 8) ? k + 1 : 5);
      @(posedge clock) ch_fault_evt <= (k < 8) ? 16'h0001 << (c * 8 + k) : 16'h0000;
      sw_short_gnd[c] <= (k == 8);
      sw_short_high[c] <= (k == 9);
      @(posedge clock) ch_fault_evt <= 16'h0000;
      sw_short_gnd <= 2'h0;
      sw_short_high <= 2'h0;
      rd("channel set", `CFR_ADDR_CH1 + 5'(c), e);
      rd("other channel", `CFR_ADDR_CH2 - 5'(c), 16'h0000);
      wr(`CFR_ADDR_CH1 + 5'(c), 16'hffff);
      rd("channel clear", `CFR_ADDR_CH1 + 5'(c), 16'h0000);
    end
  endtask : t_channel

  task automatic t_startup();
    logic [10:0] p;
    for (int i = 0; i < 2; i++) begin
      p = (i == 0) ? 11'h54d : 11'h2b2;
      @(posedge clock) boot_report_valid <= 1'h1;
      {boot_comp_fault, sense_fault_at_boot, boot_sync_state, boot_follower, boot_leader,
       pinstrap_only_operation} <= p;
      @(posedge clock) boot_report_valid <= 1'h0;
      rd("startup", `CFR_ADDR_BOOT, {5'h00, p});
      wr(`CFR_ADDR_BOOT, 16'hffff);
      rd("startup read only", `CFR_ADDR_BOOT, {5'h00, p});
    end
    wr(`CFR_ADDR_MODE, 16'h0005);
    rd("lock no match", `CFR_ADDR_BOOT, 16'h82b2);
    wr(`CFR_ADDR_MODE, 16'h0006);
    rd("lock and match", `CFR_ADDR_BOOT, 16'hc2b2);
    check("topology", operating_topology, 3'h6);
  endtask : t_startup

  task automatic t_config();
    logic [7:0] lv [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'hff};
    logic [6:0] ns [4] = '{7'h0a, 7'h14, 7'h28, 7'h3c};
    logic [9:0] mo [4] = '{10'h22b, 10'h118, 10'h0b9, 10'h08c};
    logic [7:0] a, b;
    check("buck mode", ch_buck_mode, 2'h3);
    wr(`CFR_ADDR_ENABLE, 16'hffff);
    check("enable on", ch_enable, 2'h3);
    rd("enable reserved", `CFR_ADDR_ENABLE, 16'h0003);
    wr(`CFR_ADDR_ENABLE, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      a = lv[i];
      b = lv[(i + 1) % 7];
      wr(`CFR_ADDR_LEVEL, {b, a});
      check("level one", ch_target_level[0], a);
      check("level two", ch_target_level[1], b);
      check("buck one", ch1_buck_level, (a > 8'h04) ? 3'h4 : a[2:0]);
      check("buck two", ch2_buck_level, (b > 8'h04) ? 3'h4 : b[2:0]);
    end
    rd("level read", `CFR_ADDR_LEVEL, 16'h00ff);
    for (int i = 0; i < 4; i++) begin
      wr(`CFR_ADDR_DRIVER, {8{2'(i)}});
      check("nonoverlap", ch_nonoverlap_ns, {2{ns[i]}});
      check("strength", gate_strength_mohm, {4{mo[i]}});
      rd("driver read", `CFR_ADDR_DRIVER, {8{2'(i)}});
    end
    wr(`CFR_ADDR_RESPONSE, 16'hffff);
    rd("response reserved", `CFR_ADDR_RESPONSE, 16'h00ff);
    rd("unmapped", 5'h1f, 16'h0000);
  endtask : t_config

  task automatic t_response();
    wr(`CFR_ADDR_RESPONSE, 16'h0020);
    wr(`CFR_ADDR_ENABLE, 16'h0003);
    @(posedge clock) sw_short_high <= 2'h1;
    @(posedge clock) sw_short_high <= 2'h0;
    #1 check("switch cut", ch_enable, 2'h2);
    wr(`CFR_ADDR_RESPONSE, 16'h0000);
    wr(`CFR_ADDR_ENABLE, 16'h0003);
    @(posedge clock) sw_short_gnd <= 2'h2;
    @(posedge clock) sw_short_gnd <= 2'h0;
    #1 check("hiccup", ch_hiccup, 2'h2);
    check("enable kept", ch_enable, 2'h3);
    @(posedge clock) #1 check("hiccup end", ch_hiccup, 2'h0);
    wr(`CFR_ADDR_RESPONSE, 16'h0080);
    @(posedge clock) ch_fault_evt <= 16'h4000;
    @(posedge clock) ch_fault_evt <= 16'h0000;
    #1 check("gate cut", ch_enable, 2'h1);
    rd("gate flag", `CFR_ADDR_CH2, 16'h00a0);
  endtask : t_response

  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'h1;
    t_reset();
    t_general();
    t_channel();
    t_startup();
    t_config();
    t_response();
    give_verdict();
  end
endmodule : converter_fault_config_regs_tb_top
`default_nettype wire
